// ===== rtl/csuc_pkg.sv
// Constants and types for the current-sense and user configuration block
package csuc_pkg;
  // ------------------------------------------------------------
  // Command codes and reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  CSUC_CMD_ISENSE = 8'hd0;
  localparam logic [7:0]  CSUC_CMD_USER   = 8'hd1;
  localparam logic [15:0] CSUC_ISENSE_RST = 16'h4204;
  localparam logic [15:0] CSUC_USER_RST   = 16'h0402;
  localparam int          CSUC_PAGES      = 2;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CSUC_BLANK_LSB  = 11;
  localparam int CSUC_BLANK_MSB  = 15;
  localparam int CSUC_FCNT_LSB   = 8;
  localparam int CSUC_FCNT_MSB   = 10;
  localparam int CSUC_METH_LSB   = 2;
  localparam int CSUC_METH_MSB   = 3;
  localparam int CSUC_RANGE_LSB  = 0;
  localparam int CSUC_RANGE_MSB  = 1;
  localparam int CSUC_MDUTY_LSB  = 11;
  localparam int CSUC_MDUTY_MSB  = 15;
  localparam int CSUC_DRV_BIT    = 10;
  localparam int CSUC_MDEN_BIT   = 7;
  localparam int CSUC_STRAP_BIT  = 5;
  localparam int CSUC_MRAT_BIT   = 4;
  localparam int CSUC_IDLE_BIT   = 3;
  localparam int CSUC_PGPP_BIT   = 2;
  localparam int CSUC_XTEN_BIT   = 1;
  localparam int CSUC_XTFS_BIT   = 0;
  // Writable masks: unused bits read as zero
  localparam logic [15:0] CSUC_ISENSE_MASK = 16'hff0f;
  localparam logic [15:0] CSUC_USER_MASK   = 16'hfcbf;
  // ------------------------------------------------------------
  // Encodings and timing
  // ------------------------------------------------------------
  localparam logic [1:0] CSUC_METH_DOWN  = 2'h1;
  localparam logic [1:0] CSUC_METH_UP    = 2'h2;
  localparam logic [1:0] CSUC_RANGE_LOW  = 2'h0;
  localparam logic [1:0] CSUC_RANGE_MED  = 2'h1;
  localparam logic [1:0] CSUC_RANGE_HIGH = 2'h2;
  localparam int CSUC_CLK_NS        = 4;
  localparam int CSUC_BLANK_STEP_NS = 32;
  localparam int CSUC_BLANK_STEP_CYC = (CSUC_BLANK_STEP_NS + CSUC_CLK_NS - 1) / CSUC_CLK_NS;
  localparam int CSUC_DUTY_DEN      = 512;
  // Fault detector states
  typedef enum logic [1:0] {
    CSUC_FD_IDLE  = 2'b01,
    CSUC_FD_FAULT = 2'b10
  } csuc_fd_state_t;
endpackage : csuc_pkg

// ===== rtl/csuc_fault_counter.sv
// Consecutive current-event counter for one output
`timescale 1ns/1ns
module csuc_fault_counter
  import csuc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       cycle_end,
  input  wire logic       event_in,
  input  wire logic [2:0] count_code,
  output logic            fault
);
  logic [3:0]     need;
  logic [3:0]     cnt_q;
  logic           seen_q;
  csuc_fd_state_t st_q;

  // Threshold is 2*code+1
  assign need = {count_code, 1'b1};

  // ------------------------------------------------------------
  // Event latch: one per switching cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else if (cycle_end) begin
      seen_q <= 1'b0;
    end else if (event_in) begin
      seen_q <= 1'b1;
    end
  end

  // Event in the closing cycle itself still counts for that cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 4'h0;
      st_q  <= CSUC_FD_IDLE;
    end else if (cycle_end) begin
      if (seen_q || event_in) begin
        if (cnt_q + 4'h1 >= need) begin
          st_q <= CSUC_FD_FAULT;
        end
        if (cnt_q != 4'hf) begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else begin
        cnt_q <= 4'h0;
        st_q  <= CSUC_FD_IDLE;
      end
    end
  end

  assign fault = (st_q == CSUC_FD_FAULT);

  // Fault only after a run of eventful cycles
  property p_fault_needs_run;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(fault) |-> (cnt_q >= need) && $past(cycle_end);
  endproperty
  a_fault_needs_run: assert property (p_fault_needs_run) else $error("fault rose too early");
  property p_quiet_clears;
    @(posedge clk_sys) disable iff (!rst_n)
      (cycle_end && !seen_q && !event_in) |=> (cnt_q == 4'h0) && !fault;
  endproperty
  a_quiet_clears: assert property (p_quiet_clears) else $error("quiet cycle kept count");
  property p_one_per_cycle;
    @(posedge clk_sys) disable iff (!rst_n)
      !cycle_end |=> cnt_q == $past(cnt_q);
  endproperty
  a_one_per_cycle: assert property (p_one_per_cycle) else $error("count moved mid cycle");
endmodule : csuc_fault_counter

// ===== rtl/csuc_top.sv
// Current-sense and user configuration registers with output steering
`timescale 1ns/1ns
module csuc_top
  import csuc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        page,
  input  wire logic [7:0]  cmd_code,
  input  wire logic        cmd_write,
  input  wire logic        cmd_read,
  input  wire logic [15:0] cmd_wdata,
  output logic [15:0]      cmd_rdata,
  output logic             cmd_ack,
  input  wire logic        output_enable,
  input  wire logic        pwm_raw,
  input  wire logic        pwm_low_raw,
  input  wire logic        cycle_end,
  input  wire logic        over_current_event,
  input  wire logic        under_current_event,
  input  wire logic        voltage_strap_pin_a,
  input  wire logic        voltage_strap_pin_b,
  input  wire logic        power_good,
  input  wire logic        int_temp_fault,
  input  wire logic        external_temp_sensor,
  output logic             low_side_gate_out,
  output logic             high_side_gate_out,
  output logic             power_good_out,
  output logic             power_good_oe,
  output logic             strap_level,
  output logic             margin_use_ratio,
  output logic             temp_fault,
  output logic             current_fault,
  output logic [1:0]       sense_method,
  output logic [1:0]       sense_range,
  output logic [7:0]       blank_cycles,
  output logic             min_duty_en,
  output logic [5:0]       min_duty_num
);
  // ------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;
  logic [4:0] pin_s1_q;
  logic [4:0] pin_s2_q;
  logic [4:0] pin_raw;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Pins cross into the clock domain through two stages
  assign pin_raw = {voltage_strap_pin_a, voltage_strap_pin_b, external_temp_sensor,
                    over_current_event, under_current_event};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 5'h00;
      pin_s2_q <= 5'h00;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  // ------------------------------------------------------------
  // Paged configuration words
  // ------------------------------------------------------------
  logic [15:0] isense_q [CSUC_PAGES];
  logic [15:0] user_q   [CSUC_PAGES];
  logic [15:0] isense_cur;
  logic [15:0] user_cur;
  logic        pg_q;

  assign isense_cur = isense_q[pg_q];
  assign user_cur   = user_q[pg_q];

  // Page selection is sampled so output steering follows a stable page
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= page;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < CSUC_PAGES; gi++) begin : g_page
      // Word writes only; unused bits stay zero
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          isense_q[gi] <= CSUC_ISENSE_RST;
          user_q[gi]   <= CSUC_USER_RST;
        end else if (cmd_write && (page == 1'(gi))) begin
          if (cmd_code == CSUC_CMD_ISENSE) begin
            isense_q[gi] <= cmd_wdata & CSUC_ISENSE_MASK;
          end else if (cmd_code == CSUC_CMD_USER) begin
            user_q[gi] <= cmd_wdata & CSUC_USER_MASK;
          end
        end
      end
    end
  endgenerate

  // Read answer one cycle after the request; unknown codes read zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_rdata <= 16'h0000;
      cmd_ack   <= 1'b0;
    end else begin
      cmd_ack <= cmd_read || cmd_write;
      if (cmd_read && cmd_code == CSUC_CMD_ISENSE) begin
        cmd_rdata <= isense_q[page];
      end else if (cmd_read && cmd_code == CSUC_CMD_USER) begin
        cmd_rdata <= user_q[page];
      end else if (cmd_read) begin
        cmd_rdata <= 16'h0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Current fault detection
  // ------------------------------------------------------------
  logic fault_w;
  csuc_fault_counter u_fault (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .cycle_end  (cycle_end),
    .event_in   (pin_s2_q[1] || pin_s2_q[0]),
    .count_code (isense_cur[CSUC_FCNT_MSB:CSUC_FCNT_LSB]),
    .fault      (fault_w)
  );

  // ------------------------------------------------------------
  // Sense setup decode
  // ------------------------------------------------------------
  logic [1:0] meth_f;
  logic [1:0] rng_f;
  logic [4:0] blank_f;
  assign meth_f  = isense_cur[CSUC_METH_MSB:CSUC_METH_LSB];
  assign rng_f   = isense_cur[CSUC_RANGE_MSB:CSUC_RANGE_LSB];
  assign blank_f = isense_cur[CSUC_BLANK_MSB:CSUC_BLANK_LSB];

  // Unused codes fall back to the reset choice rather than an undefined mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sense_method  <= CSUC_METH_DOWN;
      sense_range   <= CSUC_RANGE_LOW;
      blank_cycles  <= 8'h00;
      current_fault <= 1'b0;
    end else begin
      sense_method  <= (meth_f == CSUC_METH_UP) ? CSUC_METH_UP : CSUC_METH_DOWN;
      sense_range   <= (rng_f == CSUC_RANGE_HIGH) ? CSUC_RANGE_HIGH :
                       (rng_f == CSUC_RANGE_MED) ? CSUC_RANGE_MED : CSUC_RANGE_LOW;
      blank_cycles  <= 8'(blank_f * CSUC_BLANK_STEP_CYC);
      current_fault <= fault_w;
    end
  end

  // ------------------------------------------------------------
  // Duty limit, strap, margin, temperature
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      min_duty_en      <= 1'b0;
      min_duty_num     <= 6'h00;
      strap_level      <= 1'b0;
      margin_use_ratio <= 1'b0;
      temp_fault       <= 1'b0;
    end else begin
      // Numerator over 512: value+1, from 1 to 32
      min_duty_en      <= user_cur[CSUC_MDEN_BIT];
      min_duty_num     <= user_cur[CSUC_MDEN_BIT] ?
                          {user_cur[CSUC_MDUTY_MSB:CSUC_MDUTY_LSB] + 5'h01 == 5'h00 ? 1'b1 : 1'b0,
                           5'(user_cur[CSUC_MDUTY_MSB:CSUC_MDUTY_LSB] + 5'h01)} : 6'h00;
      strap_level      <= user_cur[CSUC_STRAP_BIT] ? pin_s2_q[3] : pin_s2_q[4];
      margin_use_ratio <= user_cur[CSUC_MRAT_BIT];
      // External sensor ignored unless enabled
      temp_fault       <= (user_cur[CSUC_XTFS_BIT] && user_cur[CSUC_XTEN_BIT]) ?
                          pin_s2_q[2] : int_temp_fault;
    end
  end

  // ------------------------------------------------------------
  // Gate outputs and power-good pin
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      low_side_gate_out  <= 1'b0;
      high_side_gate_out <= 1'b0;
    end else if (!output_enable) begin
      low_side_gate_out  <= user_cur[CSUC_IDLE_BIT];
      high_side_gate_out <= 1'b0;
    end else if (user_cur[CSUC_DRV_BIT]) begin
      low_side_gate_out  <= 1'b1;
      high_side_gate_out <= pwm_raw;
    end else begin
      low_side_gate_out  <= pwm_low_raw;
      high_side_gate_out <= pwm_raw;
    end
  end

  // Open-drain only pulls low; push-pull drives both levels
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      power_good_out <= 1'b0;
      power_good_oe  <= 1'b1;
    end else begin
      power_good_out <= power_good;
      power_good_oe  <= user_cur[CSUC_PGPP_BIT] ? 1'b1 : !power_good;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_idle_low;
    @(posedge clk_sys) disable iff (!rst_n)
      !output_enable |=> low_side_gate_out == $past(user_cur[CSUC_IDLE_BIT]) && !high_side_gate_out;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("idle gate level wrong");
  property p_drv_en;
    @(posedge clk_sys) disable iff (!rst_n)
      output_enable && user_cur[CSUC_DRV_BIT] |=> low_side_gate_out && high_side_gate_out == $past(pwm_raw);
  endproperty
  a_drv_en: assert property (p_drv_en) else $error("driver stage mode wrong");
  property p_direct;
    @(posedge clk_sys) disable iff (!rst_n)
      output_enable && !user_cur[CSUC_DRV_BIT] |=> low_side_gate_out == $past(pwm_low_raw);
  endproperty
  a_direct: assert property (p_direct) else $error("direct drive wrong");
  property p_od;
    @(posedge clk_sys) disable iff (!rst_n)
      !user_cur[CSUC_PGPP_BIT] |=> !(power_good_oe && power_good_out);
  endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_mduty;
    @(posedge clk_sys) disable iff (!rst_n)
      !user_cur[CSUC_MDEN_BIT] |=> !min_duty_en && min_duty_num == 6'h00;
  endproperty
  a_mduty: assert property (p_mduty) else $error("duty limit applied while off");
  property p_external_temp_sensor;
    @(posedge clk_sys) disable iff (!rst_n)
      !user_cur[CSUC_XTEN_BIT] |=> temp_fault == $past(int_temp_fault);
  endproperty
  a_external_temp_sensor: assert property (p_external_temp_sensor) else $error("external sensor used while off");
  property p_reset_user;
    @(posedge clk_sys) $rose(rst_n) |-> user_q[0] == CSUC_USER_RST && isense_q[0] == CSUC_ISENSE_RST;
  endproperty
  a_reset_user: assert property (p_reset_user) else $error("reset word wrong");
  // Readback is two steps: a user write, then a read of the same page
  sequence s_user_wr;
    cmd_write && cmd_code == CSUC_CMD_USER;
  endsequence
  sequence s_user_rd;
    cmd_read && cmd_code == CSUC_CMD_USER && page == $past(page);
  endsequence
  property p_readback;
    @(posedge clk_sys) disable iff (!rst_n)
      s_user_wr ##1 s_user_rd |=> cmd_rdata == ($past(cmd_wdata, 2) & CSUC_USER_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("user word readback wrong");
  property p_ack;
    @(posedge clk_sys) disable iff (!rst_n)
      cmd_read || cmd_write |=> cmd_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("command not acknowledged");
  // Limit numerator rebuilt from the field on its own terms
  property p_mduty_on;
    @(posedge clk_sys) disable iff (!rst_n)
      user_cur[CSUC_MDEN_BIT] |=> min_duty_en &&
        min_duty_num == ({1'b0, $past(user_cur[CSUC_MDUTY_MSB:CSUC_MDUTY_LSB])} + 6'h01);
  endproperty
  a_mduty_on: assert property (p_mduty_on) else $error("duty limit value wrong");
  property p_strap_a;
    @(posedge clk_sys) disable iff (!rst_n)
      !user_cur[CSUC_STRAP_BIT] |=> strap_level == $past(pin_s2_q[4]);
  endproperty
  a_strap_a: assert property (p_strap_a) else $error("strap pin a not selected");
  property p_strap_b;
    @(posedge clk_sys) disable iff (!rst_n)
      user_cur[CSUC_STRAP_BIT] |=> strap_level == $past(pin_s2_q[3]);
  endproperty
  a_strap_b: assert property (p_strap_b) else $error("strap pin b not selected");
  property p_xt_sel;
    @(posedge clk_sys) disable iff (!rst_n)
      user_cur[CSUC_XTEN_BIT] && user_cur[CSUC_XTFS_BIT] |=> temp_fault == $past(pin_s2_q[2]);
  endproperty
  a_xt_sel: assert property (p_xt_sel) else $error("external sensor not used for faults");
  property p_pp;
    @(posedge clk_sys) disable iff (!rst_n)
      user_cur[CSUC_PGPP_BIT] |=> power_good_oe && power_good_out == $past(power_good);
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull power-good wrong");
  property p_meth_up;
    @(posedge clk_sys) disable iff (!rst_n)
      isense_cur[CSUC_METH_MSB:CSUC_METH_LSB] == CSUC_METH_UP |=> sense_method == CSUC_METH_UP;
  endproperty
  a_meth_up: assert property (p_meth_up) else $error("up-slope sensing not selected");
endmodule : csuc_top

// ===== verif/csuc_far_model.sv
// Far-side model: board power-good wire and the host's nonvolatile copy
`timescale 1ns/1ns
module csuc_far_model
  import csuc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        power_good_out,
  input  wire logic        power_good_oe,
  output logic             pg_wire,
  output logic [15:0]      nv_user_q
);
  // ------------------------------------------------------------
  // Board wire and host store
  // ------------------------------------------------------------
  // Pull-up wins once the pin is released, so no stale level shows
  assign pg_wire = power_good_oe ? power_good_out : 1'h1;
  // Host commits every user word straight after writing it
  always_ff @(posedge clk_sys) begin
    if (cmd_write && cmd_code == CSUC_CMD_USER) begin
      nv_user_q <= cmd_wdata & CSUC_USER_MASK;
    end
  end
endmodule : csuc_far_model

// ===== verif/tb_top.sv
// Self-checking bench for the current-sense and user configuration block
`timescale 1ns/1ns
module tb_top
  import csuc_pkg::*;
;
  typedef struct {
    logic [7:0]  c;
    logic [15:0] wd, rd;
    logic [7:0]  blk;
    logic [1:0]  mt, rg;
    logic        en;
    logic [5:0]  num;
    logic        mr, st, oe;
  } csuc_row_t;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        clk_sys = 1'h0;
  logic        rstn, page, cmd_write, cmd_read, output_enable, pwm_raw, pwm_low_raw, cycle_end;
  logic        over_current_event, under_current_event, voltage_strap_pin_a, voltage_strap_pin_b;
  logic        power_good, int_temp_fault, external_temp_sensor, use_uc;
  logic        cmd_ack, low_side_gate_out, high_side_gate_out, power_good_out, power_good_oe;
  logic        strap_level, margin_use_ratio, temp_fault, current_fault, min_duty_en, pg_wire;
  logic [7:0]  cmd_code, blank_cycles;
  logic [15:0] cmd_wdata, cmd_rdata, nv_user_q, rb;
  logic [1:0]  sense_method, sense_range;
  logic [5:0]  min_duty_num;
  int          n_fail = 0;
  int          n_checks = 0;
  int          fcodes [3] = '{1, 2, 7};
  // Unused method/range codes fall back to down slope and low range
  csuc_row_t   rows [7] = '{
    '{8'hd0, 16'hffff, 16'hff0f, 8'hf8, 2'h1, 2'h0, 1'h0, 6'h00, 1'h0, 1'h1, 1'h0},
    '{8'hd0, 16'h080a, 16'h080a, 8'h08, 2'h2, 2'h2, 1'h0, 6'h00, 1'h0, 1'h1, 1'h0},
    '{8'hd0, 16'h0005, 16'h0005, 8'h00, 2'h1, 2'h1, 1'h0, 6'h00, 1'h0, 1'h1, 1'h0},
    '{8'hd1, 16'hffff, 16'hfcbf, 8'h00, 2'h1, 2'h1, 1'h1, 6'h20, 1'h1, 1'h0, 1'h1},
    '{8'hd1, 16'h0090, 16'h0090, 8'h00, 2'h1, 2'h1, 1'h1, 6'h01, 1'h1, 1'h1, 1'h0},
    '{8'hd1, 16'h7800, 16'h7800, 8'h00, 2'h1, 2'h1, 1'h0, 6'h00, 1'h0, 1'h1, 1'h0},
    '{8'hd2, 16'hffff, 16'h0000, 8'h00, 2'h1, 2'h1, 1'h0, 6'h00, 1'h0, 1'h1, 1'h0}};

  csuc_top DUT (
    .clk_sys(clk_sys), .rstn(rstn), .page(page), .cmd_code(cmd_code), .cmd_write(cmd_write),
    .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
    .output_enable(output_enable), .pwm_raw(pwm_raw), .pwm_low_raw(pwm_low_raw), .cycle_end(cycle_end),
    .over_current_event(over_current_event), .under_current_event(under_current_event),
    .voltage_strap_pin_a(voltage_strap_pin_a), .voltage_strap_pin_b(voltage_strap_pin_b),
    .power_good(power_good), .int_temp_fault(int_temp_fault), .external_temp_sensor(external_temp_sensor),
    .low_side_gate_out(low_side_gate_out), .high_side_gate_out(high_side_gate_out),
    .power_good_out(power_good_out), .power_good_oe(power_good_oe), .strap_level(strap_level),
    .margin_use_ratio(margin_use_ratio), .temp_fault(temp_fault), .current_fault(current_fault),
    .sense_method(sense_method), .sense_range(sense_range), .blank_cycles(blank_cycles),
    .min_duty_en(min_duty_en), .min_duty_num(min_duty_num));

  csuc_far_model u_far (
    .clk_sys(clk_sys), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .power_good_out(power_good_out), .power_good_oe(power_good_oe), .pg_wire(pg_wire), .nv_user_q(nv_user_q));

  // 250 MHz system clock
  always #2 clk_sys = ~clk_sys;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Inputs always move 1 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Write then read back at once; trailing gap keeps strobes single-assigned
  task automatic wr_rd(input logic [7:0] c, input logic [15:0] d, output logic [15:0] q);
    cmd_code  = c;
    cmd_wdata = d;
    cmd_write = 1'h1;
    tick(1);
    cmd_write = 1'h0;
    cmd_read  = 1'h1;
    check("wr_ack", cmd_ack, 1'h1);
    tick(1);
    cmd_read = 1'h0;
    check("rd_ack", cmd_ack, 1'h1);
    q = cmd_rdata;
    tick(1);
  endtask : wr_rd

  task automatic rd(input logic [7:0] c, output logic [15:0] q);
    cmd_code = c;
    cmd_read = 1'h1;
    tick(1);
    cmd_read = 1'h0;
    q = cmd_rdata;
    tick(1);
  endtask : rd

  // Switching cycles of 8 clocks; ev events per cycle, never more than two
  task automatic sw_cycles(input int n, input int ev);
    logic hit;
    for (int j = 0; j < n; j++) begin
      for (int k = 0; k < 8; k++) begin
        hit = (ev > 0 && k == 1) || (ev > 1 && k == 4);
        over_current_event  = hit && !use_uc;
        under_current_event = hit && use_uc;
        cycle_end           = (k == 7);
        tick(1);
      end
    end
    cycle_end = 1'h0;
    tick(1);
  endtask : sw_cycles

  task automatic do_reset();
    rstn = 1'h0;
    tick(5);
    rstn = 1'h1;
    tick(4);
  endtask : do_reset

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  // Watchdog sized well past the expected run of about 530 cycles
  initial begin
    #(CSUC_CLK_NS * 20000);
    n_fail++;
    close_out();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {rstn, page, cmd_write, cmd_read, output_enable, pwm_raw, pwm_low_raw, cycle_end} = 8'h00;
    {over_current_event, under_current_event, voltage_strap_pin_b, use_uc} = 4'h0;
    // External sensor differs from the internal one so the source choice shows
    {voltage_strap_pin_a, power_good, int_temp_fault, external_temp_sensor} = 4'hd;
    cmd_code  = 8'h00;
    cmd_wdata = 16'h0000;
    tick(2);
    check("rst_out", {sense_method, power_good_oe, current_fault}, 4'h6);
    tick(3);
    rstn = 1'h1;
    tick(4);
    for (int p = 0; p < 2; p++) begin
      page = 1'(p);
      tick(2);
      rd(CSUC_CMD_USER, rb);
      check("user_rst", rb, 16'h0402);
      rd(CSUC_CMD_ISENSE, rb);
      check("isense_rst", rb, 16'h4204);
      check("rst_fields", {blank_cycles, sense_method, sense_range, power_good_oe}, 13'h0808);
    end
    page = 1'h0;
    tick(2);
    foreach (rows[i]) begin
      wr_rd(rows[i].c, rows[i].wd, rb);
      check("readback", rb, rows[i].rd);
      check("isense_out", {blank_cycles, sense_method, sense_range}, {rows[i].blk, rows[i].mt, rows[i].rg});
      check("user_out", {min_duty_en, min_duty_num, margin_use_ratio, strap_level, power_good_oe},
            {rows[i].en, rows[i].num, rows[i].mr, rows[i].st, rows[i].oe});
    end
    // Page 1 must be untouched by the page 0 writes
    page = 1'h1;
    tick(3);
    rd(CSUC_CMD_USER, rb);
    check("page_sep", {rb, blank_cycles, sense_method}, 26'h0100901);
    {output_enable, pwm_raw} = 2'h3;
    tick(3);
    check("stage_pwm", {low_side_gate_out, high_side_gate_out}, 2'h3);
    pwm_raw = 1'h0;
    tick(3);
    check("stage_lo", {low_side_gate_out, high_side_gate_out}, 2'h2);
    output_enable = 1'h0;
    tick(3);
    check("idle_lo", {low_side_gate_out, high_side_gate_out}, 2'h0);
    wr_rd(CSUC_CMD_USER, 16'h0008, rb);
    tick(2);
    check("idle_hi", {low_side_gate_out, high_side_gate_out}, 2'h2);
    {output_enable, pwm_raw} = 2'h3;
    tick(3);
    check("direct", {low_side_gate_out, high_side_gate_out}, 2'h1);
    {pwm_raw, pwm_low_raw} = 2'h1;
    tick(3);
    check("direct_lo", {low_side_gate_out, high_side_gate_out}, 2'h2);
    // Temperature source: external only with enable and select both set
    wr_rd(CSUC_CMD_USER, 16'h0003, rb);
    tick(3);
    check("xt_both", temp_fault, 1'h1);
    wr_rd(CSUC_CMD_USER, 16'h0001, rb);
    tick(3);
    check("xt_sel", temp_fault, 1'h0);
    wr_rd(CSUC_CMD_USER, 16'h0002, rb);
    tick(3);
    check("xt_en", temp_fault, 1'h0);
    {voltage_strap_pin_a, voltage_strap_pin_b, power_good} = 3'h2;
    wr_rd(CSUC_CMD_USER, 16'h0020, rb);
    tick(3);
    check("od_low", {strap_level, power_good_oe, pg_wire}, 3'h6);
    power_good = 1'h1;
    tick(3);
    check("od_rel", {power_good_oe, pg_wire}, 2'h1);
    wr_rd(CSUC_CMD_USER, 16'h0004, rb);
    tick(3);
    check("pp_high", {strap_level, power_good_oe, pg_wire}, 3'h3);
    check("nv_copy", nv_user_q, 16'h0004);
    // Fault count: one short of 2*code+1 with doubled events, then the last
    foreach (fcodes[i]) begin
      use_uc = (fcodes[i] == 2);
      wr_rd(CSUC_CMD_ISENSE, {5'h08, 3'(fcodes[i]), 8'h04}, rb);
      sw_cycles(1, 0);
      sw_cycles(2 * fcodes[i], 2);
      tick(3);
      check("fault_early", current_fault, 1'h0);
      sw_cycles(1, 1);
      tick(3);
      check("fault_set", current_fault, 1'h1);
      sw_cycles(1, 0);
      tick(3);
      check("fault_clr", current_fault, 1'h0);
    end
    // A quiet cycle mid-run restarts the count of 15
    sw_cycles(14, 1);
    sw_cycles(1, 0);
    sw_cycles(1, 1);
    tick(3);
    check("fault_gap", current_fault, 1'h0);
    do_reset();
    rd(CSUC_CMD_USER, rb);
    check("user_rst2", rb, 16'h0402);
    close_out();
  end
endmodule : tb_top
